// ==== inc/scp_pkg.sv ====
/*
  Shared constants and types of the system clock prescaler control block.
  Assumes one master clock and a 32-bit AHB-Lite register bus.
*/
package scp_pkg;
  // Register byte offsets, decoded on haddr[7:0] with haddr[31:8] all zero
  localparam logic [7:0] TRIM_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] TCTL_OFS = 8'h0C;
  // Field positions
  localparam int DIV_CE_BIT = 7;
  localparam int SEL_MSB = 3;
  localparam int TRIM_RANGE_BIT = 7;
  localparam int STAT_CLOCK_OUTPUT_FUSE_BIT = 0;
  localparam int STAT_DIV8_BIT = 1;
  localparam int STAT_RC_BIT = 2;
  localparam int STAT_TOSC_BIT = 3;
  localparam int TCTL_REQ_BIT = 0;
  localparam int TCTL_EXT_BIT = 1;
  // Reset values and codes
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [3:0] SEL_FUSE = 4'h3;
  localparam logic [3:0] SEL_MAX = 4'h8;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_CODE = 8'h80;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  // Unlock window length in core clock cycles
  localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;

  // Unlock sequence state
  typedef enum logic {
    CHG_LOCKED = 1'b0,
    CHG_OPEN = 1'b1
  } scp_chg_t;
endpackage

// ==== inc/scp_div_if.sv ====
/*
  Link between the register side and the divider core.
  Assumes both ends sit on the same master clock.
*/
`timescale 1ns/1ps
interface scp_div_if;
  logic [3:0] sel;
  logic sel_load;
  logic tick;
  logic level;
  logic bypass;

  modport ctrl (output sel, output sel_load, input tick, input level, input bypass);
  modport div (input sel, input sel_load, output tick, output level, output bypass);
endinterface

// ==== src/scp_divider.sv ====
/*
  Divider core: a counter on the undivided clock makes the divided clock
  as a one-cycle enable and a square level for the output pin.
  Assumes sel_load is a one-cycle pulse with sel stable beside it.
*/
`timescale 1ns/1ps
module scp_divider (
  input wire logic hclk,
  input wire logic hresetn,
  scp_div_if.div dv
);
  import scp_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [3:0] act_sel_q;
  logic [3:0] pend_sel_q;
  logic pend_q;
  logic tick_q;
  logic level_q;
  logic [7:0] mask;
  logic terminal;

  // Period mask; reserved codes are clamped to the longest period
  function automatic logic [7:0] sel_mask(input logic [3:0] s);
    logic [8:0] m;
    m = 9'h000;
    if (s >= SEL_MAX) begin
      m = 9'h0FF;
    end else begin
      m = 9'(9'h001 << s) - 9'h001;
    end
    return m[7:0];
  endfunction

  assign mask = sel_mask(act_sel_q);
  assign terminal = (cnt_q == mask);
  assign cnt_d = terminal ? 8'h00 : cnt_q + 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // synchronous wrap counter
  // Counts every master edge; software never sees it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // no short period
  // A new setting waits for the running period to end, so neither the old
  // nor the new period is ever cut short.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_sel_q <= SEL_RESET;
      pend_sel_q <= SEL_RESET;
      pend_q <= 1'b0;
    end else begin
      if (terminal && pend_q) begin
        act_sel_q <= pend_sel_q;
        pend_q <= 1'b0;
      end
      // A fresh load wins over the one being consumed
      if (dv.sel_load) begin
        pend_sel_q <= dv.sel;
        pend_q <= 1'b1;
      end
    end
  end

  // two edges then new rate
  // One enable per period; the edge after the switch starts the new period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 1'b0;
      level_q <= 1'b1;
    end else begin
      tick_q <= terminal;
      level_q <= ((cnt_d & (mask ^ (mask >> 1))) == 8'h00);
    end
  end

  assign dv.tick = tick_q;
  assign dv.level = level_q;
  assign dv.bypass = (act_sel_q == SEL_RESET);
endmodule

// ==== src/scp_top.sv ====
/*
  System clock prescaler control: AHB-Lite registers for oscillator trim,
  the timed divider change, clock output pin and timer oscillator gating.
  Assumes hclk is the undivided master clock and fuse inputs are static.
*/
`timescale 1ns/1ps
module scp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic clock_output_fuse,
  input wire logic divide_by_eight_fuse,
  input wire logic [7:0] factory_trim,
  input wire logic rc_is_system_clock,
  input wire logic port_pin_out,
  input wire logic port_pin_oe,
  output logic clock_output_pin,
  output logic clock_output_pin_oe,
  output logic core_domain_clock_en,
  output logic io_domain_clock_en,
  output logic converter_domain_clock_en,
  output logic program_memory_clock_en,
  output logic trim_range_select,
  output logic [6:0] trim_fine_value,
  output logic timer_osc_enable,
  output logic external_timer_clock_select
);
  import scp_pkg::*;

  scp_div_if dv ();

  logic init_q;
  logic clock_output_fuse_fuse_q;
  logic div8_fuse_q;
  logic rc_sel_q;
  logic [7:0] trim_q;
  logic [3:0] sel_q;
  logic sel_load_q;
  scp_chg_t chg_q;
  logic [2:0] win_q;
  logic tosc_req_q;
  logic ext_clk_q;
  logic tosc_en_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic addr_phase;
  logic [7:0] wdat;
  logic wr_trim;
  logic wr_div;
  logic wr_tctl;

  // Register hit for a captured byte offset
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    return (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel && hready && (htrans == TRANS_NONSEQ);
  assign wdat = hwdata[7:0];
  assign wr_trim = wr_pend_q && reg_hit(addr_q, TRIM_OFS);
  assign wr_div = wr_pend_q && reg_hit(addr_q, DIV_OFS);
  assign wr_tctl = wr_pend_q && reg_hit(addr_q, TCTL_OFS);

  // Address phase capture; only one aligned word per register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= addr_phase && hwrite;
      rd_pend_q <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_q <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
      end
    end
  end

  // Read mux over register flops; unmapped offsets read zero
  always_comb begin
    hrdata = 32'h00000000;
    if (rd_pend_q) begin
      if (reg_hit(addr_q, TRIM_OFS)) begin
        hrdata[7:0] = trim_q;
      end else if (reg_hit(addr_q, DIV_OFS)) begin
        hrdata[DIV_CE_BIT] = (chg_q == CHG_OPEN);
        hrdata[SEL_MSB:0] = sel_q;
      end else if (reg_hit(addr_q, STAT_OFS)) begin
        hrdata[STAT_CLOCK_OUTPUT_FUSE_BIT] = clock_output_fuse_fuse_q;
        hrdata[STAT_DIV8_BIT] = div8_fuse_q;
        hrdata[STAT_RC_BIT] = rc_sel_q;
        hrdata[STAT_TOSC_BIT] = tosc_en_q;
      end else if (reg_hit(addr_q, TCTL_OFS)) begin
        hrdata[TCTL_REQ_BIT] = tosc_req_q;
        hrdata[TCTL_EXT_BIT] = ext_clk_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture static fuses
  // Fuses are sampled once, on the first edge after reset release, since
  // an asynchronous reset may only load constants.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_q <= 1'b1;
      clock_output_fuse_fuse_q <= 1'b0;
      div8_fuse_q <= 1'b0;
      rc_sel_q <= 1'b0;
    end else if (init_q) begin
      init_q <= 1'b0;
      clock_output_fuse_fuse_q <= clock_output_fuse;
      div8_fuse_q <= divide_by_eight_fuse;
      rc_sel_q <= rc_is_system_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // factory trim load
  // Software writes after the first edge overwrite the factory value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_q <= TRIM_RESET;
    end else if (init_q) begin
      trim_q <= factory_trim;
    end else if (wr_trim) begin
      trim_q <= wdat;
    end
  end

  assign trim_range_select = trim_q[TRIM_RANGE_BIT];
  assign trim_fine_value = trim_q[6:0];

  ////////////////////////////////////////////////////////////////////////////
  // unlock on clean write
  // relies on software order
  // The window counts core clock cycles, since software counts those.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg_q <= CHG_LOCKED;
      win_q <= 3'h0;
    end else begin
      case (chg_q)
        CHG_LOCKED: begin
          if (wr_div && (wdat == UNLOCK_CODE)) begin
            chg_q <= CHG_OPEN;
            win_q <= CHANGE_WINDOW_CYCLES;
          end
        end
        CHG_OPEN: begin
          if (wr_div && !wdat[DIV_CE_BIT]) begin
            chg_q <= CHG_LOCKED;
            win_q <= 3'h0;
          end else if (dv.tick) begin
            win_q <= win_q - 3'h1;
            if (win_q == 3'h1) begin
              chg_q <= CHG_LOCKED;
            end
          end
        end
        default: begin
          chg_q <= CHG_LOCKED;
          win_q <= 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q <= SEL_RESET;
      sel_load_q <= 1'b0;
    end else begin
      sel_load_q <= 1'b0;
      if (init_q) begin
        sel_q <= divide_by_eight_fuse ? SEL_FUSE : SEL_RESET;
        sel_load_q <= 1'b1;
      end else if (wr_div && !wdat[DIV_CE_BIT] && (chg_q == CHG_OPEN)) begin
        sel_q <= wdat[SEL_MSB:0];
        sel_load_q <= 1'b1;
      end
    end
  end

  assign dv.sel = sel_q;
  assign dv.sel_load = sel_load_q;

  scp_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .dv(dv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // common domain enables
  // One pulse feeds all four domains so they can never drift apart
  assign core_domain_clock_en = dv.tick;
  assign io_domain_clock_en = dv.tick;
  assign converter_domain_clock_en = dv.tick;
  assign program_memory_clock_en = dv.tick;

  // divided clock above one
  // The raw fuse is used here so the pin runs while reset is held; at
  // factor one the master clock itself goes out, as no flop can copy it.
  always_comb begin
    clock_output_pin = port_pin_out;
    clock_output_pin_oe = port_pin_oe;
    if (clock_output_fuse) begin
      clock_output_pin_oe = 1'b1;
      if (!hresetn || dv.bypass) begin
        clock_output_pin = hclk;
      end else begin
        clock_output_pin = dv.level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer oscillator control bits
  // software sets select first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tosc_req_q <= 1'b0;
      ext_clk_q <= 1'b0;
    end else if (wr_tctl) begin
      tosc_req_q <= wdat[TCTL_REQ_BIT];
      ext_clk_q <= wdat[TCTL_EXT_BIT];
    end
  end

  // gate on RC source
  // Pins are shared with the crystal, so a crystal system clock blocks them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tosc_en_q <= 1'b0;
    end else begin
      tosc_en_q <= tosc_req_q && rc_sel_q && !init_q;
    end
  end

  assign timer_osc_enable = tosc_en_q;
  assign external_timer_clock_select = ext_clk_q;
endmodule

// ==== bench/scp_monitor.sv ====
/*
  Port-level checker for the prescaler control top, bound into scp_top.
  Assumes one hclk domain and the active-low asynchronous hresetn.
*/
`timescale 1ns/1ps
module scp_monitor
  import scp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic clock_output_fuse,
  input wire logic divide_by_eight_fuse,
  input wire logic rc_is_system_clock,
  input wire logic port_pin_out,
  input wire logic port_pin_oe,
  input wire logic clock_output_pin,
  input wire logic clock_output_pin_oe,
  input wire logic core_domain_clock_en,
  input wire logic io_domain_clock_en,
  input wire logic converter_domain_clock_en,
  input wire logic program_memory_clock_en,
  input wire logic trim_range_select,
  input wire logic [6:0] trim_fine_value,
  input wire logic timer_osc_enable
);
  logic rd_stat_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Status read flag, so its data phase can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_stat_q <= 1'b0;
    end else begin
      rd_stat_q <= hsel && hready && htrans == TRANS_NONSEQ && !hwrite && haddr == 32'(STAT_OFS);
    end
  end
  // Trim write: address phase, then its data phase
  sequence s_trim_wr;
    hsel && hready && htrans == TRANS_NONSEQ && hwrite && haddr == 32'(TRIM_OFS) ##1 1'b1;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_trim_write: assert property (
    s_trim_wr |=> {trim_range_select, trim_fine_value} == $past(hwdata[7:0]))
    else $error("trim outputs miss written value");
  a_domains_together: assert property (
    {io_domain_clock_en, converter_domain_clock_en, program_memory_clock_en}
      == {3{core_domain_clock_en}}) else $error("clock domains out of step");
  a_pin_oe: assert property (
    clock_output_pin_oe == (clock_output_fuse || port_pin_oe)) else $error("pin enable wrong");
  a_port_pass: assert property (
    !clock_output_fuse |-> clock_output_pin == port_pin_out) else $error("port path broken");
  a_timer_rc: assert property (
    timer_osc_enable |-> rc_is_system_clock) else $error("timer osc without rc clock");
  a_stat_fuses: assert property (
    rd_stat_q |-> hrdata[1:0] == {divide_by_eight_fuse, clock_output_fuse})
    else $error("fuse status wrong");
  a_stat_timer: assert property (
    rd_stat_q |-> hrdata[3:2] == {timer_osc_enable, rc_is_system_clock})
    else $error("timer status wrong");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
endmodule

bind scp_top scp_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .clock_output_fuse, .divide_by_eight_fuse,
  .rc_is_system_clock, .port_pin_out, .port_pin_oe, .clock_output_pin, .clock_output_pin_oe,
  .core_domain_clock_en, .io_domain_clock_en, .converter_domain_clock_en,
  .program_memory_clock_en, .trim_range_select, .trim_fine_value, .timer_osc_enable);

// ==== bench/system_clock_prescaler_ctrl_tb_top.sv ====
/*
  Self-checking bench for the prescaler control top.
  Assumes a zero-wait AHB-Lite slave and the bound port checker.
*/
`timescale 1ns/1ps
module system_clock_prescaler_ctrl_tb_top;
  import scp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic clock_output_fuse = 1'b0;
  logic divide_by_eight_fuse = 1'b0;
  logic rc_is_system_clock = 1'b0;
  logic port_pin_out = 1'b0;
  logic port_pin_oe = 1'b0;
  logic [7:0] factory_trim = 8'h00;
  logic hready, hreadyout, hresp, clock_output_pin, clock_output_pin_oe, core_domain_clock_en;
  logic io_en, cv_en, pm_en, trim_range_select, timer_osc_enable, external_timer_clock_select;
  logic [6:0] trim_fine_value;
  logic [31:0] hrdata, rdv;
  logic [3:0] s0;
  logic [7:0] v;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed;

  scp_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .clock_output_fuse(clock_output_fuse),
    .divide_by_eight_fuse(divide_by_eight_fuse), .factory_trim(factory_trim),
    .rc_is_system_clock(rc_is_system_clock), .port_pin_out(port_pin_out),
    .port_pin_oe(port_pin_oe), .clock_output_pin(clock_output_pin),
    .clock_output_pin_oe(clock_output_pin_oe), .core_domain_clock_en(core_domain_clock_en),
    .io_domain_clock_en(io_en), .converter_domain_clock_en(cv_en),
    .program_memory_clock_en(pm_en), .trim_range_select(trim_range_select),
    .trim_fine_value(trim_fine_value), .timer_osc_enable(timer_osc_enable),
    .external_timer_clock_select(external_timer_clock_select));

  ////////////////////////////////////////////////////////////////////////////
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  // Random port traffic keeps the pin override honest
  always @(posedge hclk) begin
    {port_pin_out, port_pin_oe} <= 2'($random(seed));
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bounded wait for ready; a hang ends the run
  task rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  // One single AHB transfer, entered just after a rising edge
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= TRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rdv = hrdata;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, 32'(a), 32'h0);
    chk(rdv, e, nm);
  endtask

  task set_sel(input logic [3:0] s);
    bus(1'b1, 32'(DIV_OFS), 32'(UNLOCK_CODE));
    bus(1'b1, 32'(DIV_OFS), 32'(s));
  endtask

  // Skip the changeover, then time one divided period and the pin's high part
  task measure(input int f);
    int g, h, k;
    g = 0;
    k = 0;
    h = 0;
    while (k < 2 && g < 2000) begin
      @(posedge hclk);
      g++;
      k += (core_domain_clock_en === 1'b1);
    end
    g = 0;
    do begin
      @(posedge hclk);
      g++;
      h += (clock_output_pin === 1'b1);
    end while (core_domain_clock_en !== 1'b1 && g < 600);
    chk(g, f, "divided period");
    if (g >= 600) end_sim();
    if (clock_output_fuse && f > 1) chk(h, f / 2, "pin high cycles");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Two fuse setups, each from a fresh reset
  initial begin
    seed = 32'hd19c;
    for (int cfg = 0; cfg < 2; cfg++) begin
      hresetn <= 1'b0;
      clock_output_fuse <= (cfg == 0);
      divide_by_eight_fuse <= (cfg == 0);
      rc_is_system_clock <= (cfg == 0);
      factory_trim <= 8'($random(seed));
      repeat (11) @(posedge hclk);
      // pin follows clock in reset when the fuse is set, else the port
      // Looked at one low and one high phase, settled off the edge
      repeat (2) begin
        @(hclk);
        #1;
        v = {6'h0, clock_output_fuse | port_pin_oe, clock_output_fuse ? hclk : port_pin_out};
        chk(32'({clock_output_pin_oe, clock_output_pin}), 32'(v), "pin in reset");
      end
      hresetn <= 1'b1;
      @(posedge hclk);
      s0 = (cfg == 0) ? SEL_FUSE : SEL_RESET;
      rchk(TRIM_OFS, 32'(factory_trim), "trim reset");
      rchk(DIV_OFS, 32'(s0), "select reset");
      measure(1 << s0);
      for (int i = 0; i < 4; i++) begin
        v = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($random(seed));
        bus(1'b1, 32'(TRIM_OFS), 32'(v));
        rchk(TRIM_OFS, 32'(v), "trim read");
        chk({trim_range_select, trim_fine_value}, 32'(v), "trim pins");
      end
      bus(1'b1, 32'(DIV_OFS), 32'h5);
      bus(1'b1, 32'(DIV_OFS), 32'h81);
      rchk(DIV_OFS, 32'(s0), "locked select");
      bus(1'b1, 32'(DIV_OFS), 32'(UNLOCK_CODE));
      rchk(DIV_OFS, {24'h0, 4'h8, s0}, "unlock flag");
      if (cfg == 0) begin
        repeat (10) @(posedge hclk);
        bus(1'b1, 32'(DIV_OFS), 32'(UNLOCK_CODE));
        rchk(DIV_OFS, {24'h0, 4'h8, s0}, "rewrite keeps flag");
        repeat (20) @(posedge hclk);
        rchk(DIV_OFS, 32'(s0), "rewrite no restart");
      end
      for (int s = 0; s < 10; s++) begin
        set_sel(4'(s));
        rchk(DIV_OFS, 32'(s), "select read");
        measure(1 << ((s > 8) ? 8 : s));
      end
      set_sel(4'h0);
      // The slow period must end first, or the window would outlast the wait
      measure(1);
      bus(1'b1, 32'(DIV_OFS), 32'(UNLOCK_CODE));
      repeat (8) @(posedge hclk);
      bus(1'b1, 32'(DIV_OFS), 32'h2);
      rchk(DIV_OFS, 32'h0, "flag timeout");
      bus(1'b1, 32'(TCTL_OFS), 32'h3);
      rchk(STAT_OFS, 32'({rc_is_system_clock, rc_is_system_clock, divide_by_eight_fuse,
        clock_output_fuse}), "status");
      chk(32'(external_timer_clock_select), 32'h1, "ext timer select");
      bus(1'b1, 32'h100, 32'hFF);
      rchk(TRIM_OFS, 32'(v), "trim after unmapped");
      bus(1'b0, 32'h100, 32'h0);
      chk(rdv, 32'h0, "unmapped read");
    end
    end_sim();
  end
endmodule
